// ### verilog/pps_pkg.sv
// Shared constants, types and decoders for the parameter save and restore block
package pps_pkg;

   // Object indices
   localparam logic [15:0] IDX_STORE   = 16'h1010;
   localparam logic [15:0] IDX_RESTORE = 16'h1011;
   localparam logic [15:0] IDX_MARKER  = 16'h1020;
   localparam logic [15:0] IDX_REBOOT  = 16'h2800;

   // Subindices
   localparam logic [7:0] SUB_ALL    = 8'h01;
   localparam logic [7:0] SUB_COMM   = 8'h02;
   localparam logic [7:0] SUB_APP    = 8'h03;
   localparam logic [7:0] SUB_CUST   = 8'h04;
   localparam logic [7:0] SUB_DRIVE  = 8'h05;
   localparam logic [7:0] SUB_TUNE   = 8'h06;
   localparam logic [7:0] SUB_ETH    = 8'h0c;
   localparam logic [7:0] SUB_DATE   = 8'h01;
   localparam logic [7:0] SUB_TIME   = 8'h02;
   localparam logic [7:0] SUB_COUNT  = 8'h0c;

   // Key values
   localparam logic [31:0] KEY_SAVE    = 32'h65766173;
   localparam logic [31:0] KEY_DISCARD = 32'h64616f6c;
   localparam logic [31:0] KEY_REBOOT  = 32'h746f6f62;
   localparam logic [31:0] SAVE_DONE   = 32'h00000001;
   localparam logic [31:0] MARK_CLEAR  = 32'h00000000;

   // Category mask bits
   localparam int CAT_W     = 6;
   localparam int CAT_COMM  = 0;
   localparam int CAT_APP   = 1;
   localparam int CAT_CUST  = 2;
   localparam int CAT_DRIVE = 3;
   localparam int CAT_TUNE  = 4;
   localparam int CAT_ETH   = 5;
   localparam logic [CAT_W-1:0] CAT_NONE     = 6'h00;
   localparam logic [CAT_W-1:0] CAT_ALL_MASK = 6'h0f;
   localparam logic [CAT_W-1:0] CAT_LOAD_ALL = 6'h3f;

   // Store slots, one per store subindex
   localparam int SLOT_N = 7;
   localparam logic [2:0] SLOT_ETH = 3'h6;

   typedef enum logic [1:0] {
      OP_LOAD  = 2'h0,
      OP_SAVE  = 2'h1,
      OP_ERASE = 2'h2
   } pps_op_e;

   typedef enum logic [2:0] {
      ST_LOAD = 3'b001,
      ST_IDLE = 3'b010,
      ST_BUSY = 3'b100
   } pps_state_e;

   typedef struct packed {
      logic        wr;
      logic [15:0] index;
      logic [7:0]  sub;
      logic [31:0] data;
   } pps_od_req_s;

   typedef struct packed {
      logic [31:0] date;
      logic [31:0] time_of_day;
   } pps_mark_s;

   // Store subindex to slot number
   function automatic logic [2:0] pps_slot(input logic [7:0] sub);
      if (sub == SUB_ETH) begin
         return SLOT_ETH;
      end
      return 3'(sub - SUB_ALL);
   endfunction

endpackage

// ### verilog/pps_sub_map.sv
// Store and restore subindex to category mask decoder
module pps_sub_map
   import pps_pkg::*;
(
   // Subindex in
   input  wire logic [7:0]       sub,
   // Category mask out
   output logic      [CAT_W-1:0] cat,
   output logic                  known
);

   always_comb begin
      known = 1'b1;
      case (sub)
         SUB_ALL:   cat = CAT_ALL_MASK;
         SUB_COMM:  cat = CAT_W'(1 << CAT_COMM);
         SUB_APP:   cat = CAT_W'(1 << CAT_APP);
         SUB_CUST:  cat = CAT_W'(1 << CAT_CUST);
         SUB_DRIVE: cat = CAT_W'(1 << CAT_DRIVE);
         SUB_TUNE:  cat = CAT_W'(1 << CAT_TUNE);
         SUB_ETH:   cat = CAT_W'(1 << CAT_ETH);
         default: begin
            cat   = CAT_NONE;
            known = 1'b0;
         end
      endcase
   end

endmodule

// ### verilog/pps_obj_class.sv
// Object index to savable category classifier
module pps_obj_class
   import pps_pkg::*;
(
   // Object index in
   input  wire logic [15:0]      index,
   // Category mask out, zero when the object is not savable
   output logic      [CAT_W-1:0] cat
);

   always_comb begin
      case (index)
         16'h2102, 16'h3501, 16'h3502, 16'h3601, 16'h3602:
            cat = CAT_W'(1 << CAT_COMM);
         16'h2701:
            cat = CAT_W'(1 << CAT_CUST);
         16'h3202, 16'h320d, 16'h320e, 16'h320f, 16'h6073, 16'h6080:
            cat = CAT_W'(1 << CAT_DRIVE);
         16'h2030, 16'h2031, 16'h203b, 16'h2059, 16'h3203, 16'h3390,
         16'h33a0, 16'h6075, 16'h608f, 16'h6090, 16'h60e6, 16'h60eb:
            cat = CAT_W'(1 << CAT_TUNE);
         16'h2010, 16'h2011, 16'h2012, 16'h2013:
            cat = CAT_W'(1 << CAT_ETH);
         IDX_REBOOT:
            cat = CAT_W'(1 << CAT_APP);
         default:
            cat = CAT_NONE;
      endcase
   end

endmodule

// ### verilog/pps_core.sv
// Parameter save, discard, reboot and modification marker control
module pps_core
   import pps_pkg::*;
(
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              sys_rst,
   // Object dictionary access
   input  wire logic              od_valid,
   input  wire pps_od_req_s       od_req,
   input  wire logic              od_app_savable,
   output logic                   od_ack,
   output logic                   od_err,
   output logic       [31:0]      od_rdata,
   // Non-volatile memory engine
   output logic                   nvm_start,
   output pps_op_e                nvm_op,
   output logic       [CAT_W-1:0] nvm_cat,
   output pps_mark_s              nvm_mark,
   input  wire logic              nvm_done,
   input  wire pps_mark_s         nvm_load_mark,
   // Controller status
   output logic                   load_done,
   output logic                   ctrl_restart
);

   pps_state_e        state;
   logic              load_issued;
   logic [2:0]        act_slot;
   logic [31:0]       store_val [SLOT_N];
   pps_mark_s         marker;
   logic [CAT_W-1:0]  sub_cat;
   logic              sub_known;
   logic [CAT_W-1:0]  obj_cat;
   logic              wr;
   logic              rd;
   logic              idle;
   logic              wr_store;
   logic              wr_restore;
   logic              wr_marker;
   logic              wr_reboot;
   logic              save_go;
   logic              erase_go;
   logic              op_refused;
   logic              savable_wr;
   logic [31:0]       next_rdata;

   pps_sub_map u_sub_map (
      .sub   (od_req.sub),
      .cat   (sub_cat),
      .known (sub_known)
   );

   pps_obj_class u_obj_class (
      .index (od_req.index),
      .cat   (obj_cat)
   );

   // Request decode
   assign wr         = od_valid && od_req.wr;
   assign rd         = od_valid && !od_req.wr;
   assign idle       = (state == ST_IDLE);
   assign wr_store   = wr && od_req.index == IDX_STORE && sub_known;
   assign wr_restore = wr && od_req.index == IDX_RESTORE && sub_known;
   assign wr_marker  = wr && od_req.index == IDX_MARKER &&
                       (od_req.sub == SUB_DATE || od_req.sub == SUB_TIME);
   assign wr_reboot  = wr && od_req.index == IDX_REBOOT && od_req.sub == SUB_ALL &&
                       od_req.data == KEY_REBOOT;
   assign save_go    = wr_store && idle && od_req.data == KEY_SAVE;
   assign erase_go   = wr_restore && idle && od_req.data == KEY_DISCARD;
   assign op_refused = (wr_store || wr_restore) && !idle;
   // Savable: any categorised object, an object flagged by od_app_savable, or a store subindex other than 01
   assign savable_wr = wr && ((obj_cat != CAT_NONE) || od_app_savable ||
                       (wr_store && od_req.sub != SUB_ALL));

   // Sequencer
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_LOAD;
      end else begin
         case (state)
            ST_LOAD: begin
               if (load_issued && nvm_done) begin
                  state <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (save_go || erase_go) begin
                  state <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (nvm_done) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_LOAD;
         endcase
      end
   end

   // Memory engine commands
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_issued <= 1'b0;
         nvm_start   <= 1'b0;
         nvm_op      <= OP_LOAD;
         nvm_cat     <= CAT_NONE;
         act_slot    <= 3'h0;
      end else begin
         nvm_start <= 1'b0;
         if (state == ST_LOAD && !load_issued) begin
            load_issued <= 1'b1;
            nvm_start   <= 1'b1;
            nvm_op      <= OP_LOAD;
            nvm_cat     <= CAT_LOAD_ALL;
         end else if (save_go || erase_go) begin
            nvm_start <= 1'b1;
            nvm_op    <= save_go ? OP_SAVE : OP_ERASE;
            nvm_cat   <= sub_cat;
            act_slot  <= pps_slot(od_req.sub);
         end
      end
   end

   // Load completion
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         load_done <= 1'b0;
      end else if (state == ST_LOAD && load_issued && nvm_done) begin
         load_done <= 1'b1;
      end
   end

   // Store subindex values
   genvar g;
   generate
      for (g = 0; g < SLOT_N; g++) begin : g_slot
         always_ff @(posedge core_clk or posedge sys_rst) begin
            if (sys_rst) begin
               store_val[g] <= SAVE_DONE;
            end else if (state == ST_BUSY && nvm_done && nvm_op == OP_SAVE &&
                         act_slot == 3'(g)) begin
               store_val[g] <= SAVE_DONE;
            end else if (save_go && pps_slot(od_req.sub) == 3'(g)) begin
               store_val[g] <= od_req.data;
            end
         end
      end
   endgenerate

   // Modification marker
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         marker <= '0;
      end else if (state == ST_LOAD && load_issued && nvm_done) begin
         marker <= nvm_load_mark;
      end else if (wr_marker && od_req.sub == SUB_DATE) begin
         marker.date <= od_req.data;
      end else if (wr_marker) begin
         marker.time_of_day <= od_req.data;
      end else if (savable_wr) begin
         marker <= {MARK_CLEAR, MARK_CLEAR};
      end
   end

   // Marker image handed to the memory engine with each save of store subindex 01
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         nvm_mark <= '0;
      end else if (save_go && od_req.sub == SUB_ALL) begin
         nvm_mark <= marker;
      end
   end

   // Restart request; a discard never drives it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_restart <= 1'b0;
      end else begin
         ctrl_restart <= wr_reboot;
      end
   end

   // Read data
   always_comb begin
      next_rdata = 32'h00000000;
      if (rd && od_req.index == IDX_STORE && sub_known) begin
         next_rdata = store_val[pps_slot(od_req.sub)];
      end else if (rd && od_req.index == IDX_STORE && od_req.sub == 8'h00) begin
         next_rdata = 32'(SUB_COUNT);
      end else if (rd && od_req.index == IDX_MARKER && od_req.sub == SUB_DATE) begin
         next_rdata = marker.date;
      end else if (rd && od_req.index == IDX_MARKER && od_req.sub == SUB_TIME) begin
         next_rdata = marker.time_of_day;
      end
   end

   // Answer
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         od_ack   <= 1'b0;
         od_err   <= 1'b0;
         od_rdata <= 32'h00000000;
      end else begin
         od_ack   <= od_valid;
         od_err   <= op_refused;
         od_rdata <= next_rdata;
      end
   end

   // Checks
   sequence s_save_write;
      save_go;
   endsequence

   sequence s_save_issued;
      nvm_start && nvm_op == OP_SAVE;
   endsequence

   property p_save_start;
      @(posedge core_clk) disable iff (sys_rst)
      s_save_write |=> s_save_issued ##0 (state == ST_BUSY);
   endproperty
   a_save_start: assert property (p_save_start) else $error("save key did not start a save");

   property p_save_done;
      @(posedge core_clk) disable iff (sys_rst)
      (state == ST_BUSY && nvm_op == OP_SAVE && nvm_done) |=> (store_val[act_slot] == SAVE_DONE);
   endproperty
   a_save_done: assert property (p_save_done) else $error("store subindex not one after save");

   property p_factory_keep;
      @(posedge core_clk) disable iff (sys_rst)
      (erase_go && od_req.sub == SUB_ALL) |=> (nvm_cat[CAT_TUNE] == 1'b0 && nvm_cat[CAT_ETH] == 1'b0);
   endproperty
   a_factory_keep: assert property (p_factory_keep) else $error("factory reset hit tuning or Ethernet");

   property p_tune_erase;
      @(posedge core_clk) disable iff (sys_rst)
      (erase_go && od_req.sub == SUB_TUNE) |=> (nvm_op == OP_ERASE && nvm_cat == CAT_W'(1 << CAT_TUNE));
   endproperty
   a_tune_erase: assert property (p_tune_erase) else $error("tuning discard not issued");

   property p_bad_key;
      @(posedge core_clk) disable iff (sys_rst)
      (load_issued && ((wr_store && od_req.data != KEY_SAVE) || (wr_restore && od_req.data != KEY_DISCARD)))
         |=> !nvm_start;
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("wrong key started an operation");

   property p_reboot;
      @(posedge core_clk) disable iff (sys_rst)
      wr_reboot |=> ctrl_restart;
   endproperty
   a_reboot: assert property (p_reboot) else $error("reboot key did not restart");

   property p_discard_no_restart;
      @(posedge core_clk) disable iff (sys_rst)
      (erase_go && !wr_reboot) |=> !ctrl_restart ##1 (state == ST_BUSY || state == ST_IDLE);
   endproperty
   a_discard_no_restart: assert property (p_discard_no_restart) else $error("discard forced restart");

   property p_mark_clear;
      @(posedge core_clk) disable iff (sys_rst)
      (state != ST_LOAD && savable_wr && !wr_marker) |=> (marker == '0);
   endproperty
   a_mark_clear: assert property (p_mark_clear) else $error("marker not cleared");

   property p_mark_keep;
      @(posedge core_clk) disable iff (sys_rst)
      (state != ST_LOAD && wr_store && od_req.sub == SUB_ALL && !savable_wr) |=> (marker == $past(marker));
   endproperty
   a_mark_keep: assert property (p_mark_keep) else $error("save all cleared marker");

   property p_mark_saved;
      @(posedge core_clk) disable iff (sys_rst)
      (save_go && od_req.sub == SUB_ALL) |=> (nvm_mark == $past(marker));
   endproperty
   a_mark_saved: assert property (p_mark_saved) else $error("marker not passed with save all");

   property p_load_first;
      @(posedge core_clk) disable iff (sys_rst)
      (state == ST_LOAD && load_issued && nvm_done) |=> (load_done && state == ST_IDLE);
   endproperty
   a_load_first: assert property (p_load_first) else $error("reload did not complete");

   property p_cat_whole;
      @(posedge core_clk) disable iff (sys_rst)
      nvm_start |-> (nvm_cat != CAT_NONE);
   endproperty
   a_cat_whole: assert property (p_cat_whole) else $error("operation with empty category");

endmodule

// ### verification/pps_nvm_model.sv
// Behavioural non-volatile memory engine facing the save and restore block
module pps_nvm_model
   import pps_pkg::*;
#(
   parameter logic [63:0] INIT_MARK = 64'h0000001100000022
)
(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   // Engine requests
   input  wire logic             nvm_start,
   input  wire pps_op_e          nvm_op,
   input  wire logic [CAT_W-1:0] nvm_cat,
   input  wire pps_mark_s        nvm_mark,
   input  wire logic [7:0]       lat,
   // Engine answers
   output logic                  nvm_done,
   output pps_mark_s             nvm_load_mark
);
   timeunit 1ns;
   timeprecision 1ps;
   pps_mark_s  saved = INIT_MARK;
   logic [7:0] cnt;
   // Stored marker valid only with done
   assign nvm_load_mark = nvm_done ? saved : pps_mark_s'(~saved);
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         nvm_done <= 1'b0;
         cnt      <= 8'h00;
      end else begin
         nvm_done <= 1'b0;
         if (nvm_start) begin
            cnt <= lat;
            if (nvm_op == OP_SAVE && nvm_cat == CAT_ALL_MASK) begin
               saved <= nvm_mark;
            end
         end else if (cnt == 8'h01) begin
            cnt      <= 8'h00;
            nvm_done <= 1'b1;
         end else if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule

// ### verification/pps_core_bench.sv
// Self-checking bench for the parameter save and restore core
module pps_core_bench
   import pps_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] MK = 32'h0000beef;
   typedef struct {
      logic        wr;
      logic [15:0] idx;
      logic [7:0]  sub;
      logic [31:0] dat;
      logic        app;
      logic [31:0] rd;
      logic [31:0] mk;
   } pps_row_s;
   logic             core_clk, sys_rst, od_valid, od_app_savable, od_ack, od_err;
   logic             nvm_start, nvm_done, load_done, ctrl_restart;
   logic             g_ack, g_err, g_start, g_rst;
   pps_od_req_s      od_req;
   logic [31:0]      od_rdata, g_rd;
   pps_op_e          nvm_op;
   logic [CAT_W-1:0] nvm_cat;
   pps_mark_s        nvm_mark, nvm_load_mark;
   logic [7:0]       lat;
   int               err_total, tests_run, cyc;
   logic [7:0]       subs [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0c};
   logic [5:0]       cats [7] = '{6'h0f, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
   pps_row_s         rows [12] = '{
      '{0, 'h1010, 'h00, 0, 0, 'h0c, MK}, '{0, 'h1010, 'h01, 0, 0, 'h1, MK},
      '{0, 'h1010, 'h0c, 0, 0, 'h1, MK},  '{0, 'h1011, 'h01, 0, 0, 'h0, MK},
      '{1, 'h3202, 'h00, 5, 0, 0, 0},     '{1, 'h6080, 'h00, 5, 0, 0, 0},
      '{1, 'h2030, 'h00, 5, 0, 0, 0},     '{1, 'h60eb, 'h00, 5, 0, 0, 0},
      '{1, 'h2010, 'h00, 5, 0, 0, 0},     '{1, 'h2701, 'h00, 5, 0, 0, 0},
      '{1, 'h4013, 'h00, 5, 1, 0, 0},     '{1, 'h6041, 'h00, 5, 0, 0, MK}};

   pps_core DUT (.core_clk(core_clk), .sys_rst(sys_rst), .od_valid(od_valid), .od_req(od_req),
      .od_app_savable(od_app_savable), .od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata),
      .nvm_start(nvm_start), .nvm_op(nvm_op), .nvm_cat(nvm_cat), .nvm_mark(nvm_mark),
      .nvm_done(nvm_done), .nvm_load_mark(nvm_load_mark), .load_done(load_done),
      .ctrl_restart(ctrl_restart));
   pps_nvm_model nvm (.core_clk(core_clk), .sys_rst(sys_rst), .nvm_start(nvm_start), .nvm_op(nvm_op),
      .nvm_cat(nvm_cat), .nvm_mark(nvm_mark), .lat(lat), .nvm_done(nvm_done),
      .nvm_load_mark(nvm_load_mark));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic close_out;
      $display("tests_run=%0d err_total=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One request, answer sampled one cycle later
   task automatic od_op(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] dat, input logic app = 1'b0);
      @(posedge core_clk);
      od_valid       <= 1'b1;
      od_req         <= '{wr, idx, sub, dat};
      od_app_savable <= app;
      @(posedge core_clk);
      od_valid       <= 1'b0;
      od_app_savable <= 1'b0;
      #1;
      {g_ack, g_err, g_start, g_rst, g_rd} = {od_ack, od_err, nvm_start, ctrl_restart, od_rdata};
      chk(32'(g_ack), 32'h1);
   endtask

   task automatic wait_save(input logic [7:0] sub);
      for (int i = 0; i < 40; i++) begin
         od_op(1'b0, IDX_STORE, sub, 32'h0);
         if (g_rd === SAVE_DONE) break;
      end
   endtask

   task automatic wait_idle;
      for (int i = 0; i < 60; i++) begin
         @(posedge core_clk);
         #1;
         if (nvm_done === 1'b1) break;
      end
      @(posedge core_clk);
   endtask

   task automatic do_reset;
      @(posedge core_clk);
      sys_rst <= 1'b1;
      @(posedge core_clk);
      #1 chk(32'({od_ack, nvm_start, load_done, ctrl_restart}), 32'h0);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1 chk(32'({nvm_start, nvm_op, nvm_cat}), {23'h0, 1'b1, OP_LOAD, CAT_LOAD_ALL});
   endtask

   initial begin
      {sys_rst, od_valid, od_app_savable, od_req, lat} = {1'b1, 1'b0, 1'b0, 57'h0, 8'd8};
      do_reset();
      od_op(1'b1, IDX_STORE, SUB_COMM, KEY_SAVE);
      chk(32'({g_err, g_start}), 32'h2);
      wait_idle();
      od_op(1'b0, IDX_MARKER, SUB_DATE, 32'h0);
      chk(g_rd, 32'h00000011);
      chk(32'(load_done), 32'h1);
      $display("reset and load test done");
      foreach (rows[i]) begin
         od_op(1'b1, IDX_MARKER, SUB_DATE, MK);
         od_op(rows[i].wr, rows[i].idx, rows[i].sub, rows[i].dat, rows[i].app);
         if (!rows[i].wr) begin
            chk(g_rd, rows[i].rd);
         end
         od_op(1'b0, IDX_MARKER, SUB_DATE, 32'h0);
         chk(g_rd, rows[i].mk);
      end
      $display("table test done");
      lat <= 8'd20;
      for (int k = 0; k < 2; k++) begin
         foreach (subs[i]) begin
            od_op(1'b1, IDX_MARKER, SUB_DATE, MK);
            od_op(1'b1, k ? IDX_RESTORE : IDX_STORE, subs[i], k ? KEY_DISCARD : KEY_SAVE);
            chk(32'({g_start, g_rst}), 32'h2);
            chk(32'(nvm_op), k ? 32'(OP_ERASE) : 32'(OP_SAVE));
            chk(32'(nvm_cat), 32'(cats[i]));
            if (k == 0) begin
               chk(nvm_mark.date, MK);
               od_op(1'b0, IDX_STORE, subs[i], 32'h0);
               chk(g_rd, KEY_SAVE);
               od_op(1'b0, IDX_MARKER, SUB_DATE, 32'h0);
               chk(g_rd, i == 0 ? MK : MARK_CLEAR);
               od_op(1'b1, IDX_STORE, subs[i], KEY_SAVE);
               chk(32'({g_err, g_start}), 32'h2);
               wait_save(subs[i]);
               chk(g_rd, SAVE_DONE);
            end else begin
               wait_idle();
            end
         end
      end
      $display("save and discard test done");
      od_op(1'b1, IDX_STORE, SUB_DRIVE, KEY_SAVE ^ 32'h1);
      chk(32'({g_start, g_err}), 32'h0);
      od_op(1'b0, IDX_STORE, SUB_DRIVE, 32'h0);
      chk(g_rd, SAVE_DONE);
      od_op(1'b1, IDX_RESTORE, SUB_TUNE, KEY_SAVE);
      chk(32'(g_start), 32'h0);
      $display("wrong key test done");
      lat <= 8'd6;
      od_op(1'b1, IDX_MARKER, SUB_DATE, 32'h00000a1b);
      od_op(1'b1, IDX_MARKER, SUB_TIME, 32'h00000c2d);
      // Motor idle, no other traffic until done
      od_op(1'b1, IDX_STORE, SUB_ALL, KEY_SAVE);
      wait_save(SUB_ALL);
      chk(g_rd, SAVE_DONE);
      od_op(1'b1, IDX_REBOOT, 8'h01, KEY_REBOOT);
      chk(32'(g_rst), 32'h1);
      @(posedge core_clk);
      #1 chk(32'(ctrl_restart), 32'h0);
      do_reset();
      wait_idle();
      od_op(1'b0, IDX_MARKER, SUB_DATE, 32'h0);
      chk(g_rd, 32'h00000a1b);
      od_op(1'b0, IDX_MARKER, SUB_TIME, 32'h0);
      chk(g_rd, 32'h00000c2d);
      chk(32'(load_done), 32'h1);
      $display("restart test done");
      close_out();
   end
endmodule
